/* File: core/mdt_pkg.sv */
// constants for the multimode delay timer
// assumes a single 250 MHz clock and asynchronous contact inputs
// Overview of operation
// [R1] mode setting picks one of four behaviours
// [R2] on-delay: output on after set time, latched
// [R3] power-off or reset clears everything
// [R4] stop freezes elapsed time and output; a differential start edge still restarts the pulse under stop
// [R5] stop release resumes from frozen value
// [R6] off-start flicker: off phase first
// [R7] off-start flicker: equal phases alternate forever
// [R8] on-start flicker: on first, then alternate
// [R9] differential: pulse on each start edge
// [R10] differential: start change restarts pulse time
// [R11] hold start asserted for power-up timing
// [R12] intervals counted in clock-derived ticks
`default_nettype none
package mdt_pkg;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 4;
    // one timing tick in ns
    localparam int TICK_NS = 1000;
    // clock cycles per tick, rounded down, at least one
    localparam int TICK_CYC_RAW = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_CYC = (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;
    // width of the tick prescaler
    localparam int PRE_W = 8;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
    // width of the set time and elapsed counter
    localparam int TIME_W = 16;
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
    localparam logic [TIME_W-1:0] TIME_ONE = 16'h0001;
    // operation modes
    typedef enum logic [1:0] {
        MDT_ON_DELAY = 2'h0,
        MDT_OFF_START_FLICKER = 2'h1,
        MDT_ON_START_FLICKER = 2'h2,
        MDT_DIFFERENTIAL = 2'h3
    } mdt_mode_t;
    // controller states, gray along idle-run-done
    typedef enum logic [1:0] {
        MDT_IDLE = 2'h0,
        MDT_RUN = 2'h1,
        MDT_DONE = 2'h3
    } mdt_state_t;
endpackage
`default_nettype wire

/* File: core/mdt_timer.sv */
// multimode delay timer: one timed output driven by contact inputs
// assumes contacts are asynchronous; reset doubles as power-off
// assumes mode and set time are static settings, moved only under reset
`timescale 1ns/100ps
`default_nettype none
module mdt_timer
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic [1:0] MODE_I,
    input wire logic [mdt_pkg::TIME_W-1:0] SET_TIME_I,
    input wire logic START_I,
    input wire logic RESET_I,
    input wire logic STOP_I,
    output logic OUT_O
);
    // two-flop synchronisers for contact pins
    logic [2:0] sync1;
    logic [2:0] sync2;
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end
        else if (CE_I)
        begin
            sync1 <= {STOP_I, RESET_I, START_I};
            sync2 <= sync1;
        end
    end
    logic start_s;
    logic reset_s;
    logic stop_s;
    assign start_s = sync2[0];
    assign reset_s = sync2[1];
    assign stop_s = sync2[2];

    // previous start for edge detection
    logic start_d;
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            start_d <= 1'h0;
        else if (CE_I)
            start_d <= start_s;
    end
    logic start_rise;
    logic start_edge;
    assign start_rise = start_s & ~start_d;
    assign start_edge = start_s ^ start_d;

    // mode decode
    mdt_pkg::mdt_mode_t mode;
    assign mode = mdt_pkg::mdt_mode_t'(MODE_I); // R1

    // tick prescaler, frozen by stop so partial ticks are kept too
    logic [mdt_pkg::PRE_W-1:0] pre;
    logic tick;
    assign tick = (pre == mdt_pkg::PRE_LAST) && !stop_s;
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            pre <= mdt_pkg::PRE_ZERO;
        else if (CE_I)
        begin
            if (reset_s)
                pre <= mdt_pkg::PRE_ZERO; // R3
            else if (stop_s)
                pre <= pre; // R4
            else if (tick)
                pre <= mdt_pkg::PRE_ZERO; // R12
            else
                pre <= pre + 8'h01;
        end
    end

    // main controller
    mdt_pkg::mdt_state_t state;
    logic [mdt_pkg::TIME_W-1:0] elapsed;
    logic out_q;
    logic expire;
    // a zero set time still waits one tick, so phases never vanish
    assign expire = tick && (elapsed + mdt_pkg::TIME_ONE >= SET_TIME_I);
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state <= mdt_pkg::MDT_IDLE;
            elapsed <= mdt_pkg::TIME_ZERO;
            out_q <= 1'h0;
        end
        else if (CE_I)
        begin
            if (reset_s)
            begin
                // reset contact clears all; start must re-close to retrigger, or just change in differential mode
                state <= mdt_pkg::MDT_IDLE; // R3
                elapsed <= mdt_pkg::TIME_ZERO;
                out_q <= 1'h0;
            end
            else if (mode == mdt_pkg::MDT_DIFFERENTIAL && start_edge)
            begin
                // either start edge (re)opens the pulse window
                state <= mdt_pkg::MDT_RUN; // R9
                elapsed <= mdt_pkg::TIME_ZERO; // R10
                out_q <= 1'h1;
            end
            else
            begin
                unique case (state)
                    mdt_pkg::MDT_IDLE:
                    begin
                        // start rise arms the non-differential modes
                        if (start_rise && mode != mdt_pkg::MDT_DIFFERENTIAL)
                        begin
                            state <= mdt_pkg::MDT_RUN;
                            elapsed <= mdt_pkg::TIME_ZERO;
                            out_q <= (mode == mdt_pkg::MDT_ON_START_FLICKER); // R6 R8
                        end
                    end
                    mdt_pkg::MDT_RUN:
                    begin
                        if (stop_s)
                            elapsed <= elapsed; // R4 R5
                        else if (expire)
                        begin
                            elapsed <= mdt_pkg::TIME_ZERO;
                            unique case (mode)
                                mdt_pkg::MDT_ON_DELAY:
                                begin
                                    out_q <= 1'h1; // R2
                                    state <= mdt_pkg::MDT_DONE;
                                end
                                mdt_pkg::MDT_DIFFERENTIAL:
                                begin
                                    out_q <= 1'h0; // R9
                                    state <= mdt_pkg::MDT_IDLE;
                                end
                                // both flicker modes toggle each phase
                                mdt_pkg::MDT_OFF_START_FLICKER,
                                mdt_pkg::MDT_ON_START_FLICKER:
                                    out_q <= ~out_q; // R7 R8
                            endcase
                        end
                        else if (tick)
                            elapsed <= elapsed + mdt_pkg::TIME_ONE; // R12
                    end
                    mdt_pkg::MDT_DONE:
                        out_q <= 1'h1; // R2
                    default:
                        state <= mdt_pkg::MDT_IDLE;
                endcase
            end
        end
    end
    assign OUT_O = out_q;

    // stop must hold both counter and output
    stop_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R4
        (CE_I && $past(CE_I) && $past(stop_s) && stop_s && !reset_s && $past(!reset_s)
         && mode != mdt_pkg::MDT_DIFFERENTIAL && $past(state) == mdt_pkg::MDT_RUN)
        |-> $stable(elapsed) && $stable(out_q))
        else $error("stop did not freeze timing");
    // reset contact clears output next cycle
    reset_clear_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R3
        (CE_I && reset_s) |=> !out_q && elapsed == mdt_pkg::TIME_ZERO)
        else $error("reset did not clear");
    // on-delay output latches once set
    ondelay_latch_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R2
        (state == mdt_pkg::MDT_DONE && !reset_s && CE_I) |=> out_q)
        else $error("on-delay output dropped");
    // differential edge turns output on
    diff_edge_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R9 R10
        (CE_I && !reset_s && mode == mdt_pkg::MDT_DIFFERENTIAL && start_edge)
        |=> out_q && elapsed == mdt_pkg::TIME_ZERO)
        else $error("differential pulse missing");
    // on-start flicker begins on
    onflick_start_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R8
        (CE_I && !reset_s && state == mdt_pkg::MDT_IDLE && start_rise
         && mode == mdt_pkg::MDT_ON_START_FLICKER) |=> out_q)
        else $error("on-start flicker began off");
    // off-start flicker begins off
    offflick_start_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R6
        (CE_I && !reset_s && state == mdt_pkg::MDT_IDLE && start_rise
         && mode == mdt_pkg::MDT_OFF_START_FLICKER) |=> !out_q)
        else $error("off-start flicker began on");
    // flicker toggles on expiry
    flick_toggle_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R7
        (CE_I && !reset_s && !stop_s && expire && state == mdt_pkg::MDT_RUN
         && (mode == mdt_pkg::MDT_OFF_START_FLICKER || mode == mdt_pkg::MDT_ON_START_FLICKER))
        |=> out_q != $past(out_q))
        else $error("flicker did not toggle");
    // elapsed never passes set time while running
    elapsed_bound_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R5 R12
        (state == mdt_pkg::MDT_RUN && SET_TIME_I != mdt_pkg::TIME_ZERO && $stable(SET_TIME_I))
        |-> elapsed < SET_TIME_I)
        else $error("elapsed overran set time");
    // clock enable low holds every state bit, prescaler included
    ce_freeze_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R12
        !CE_I |=> $stable(state) && $stable(elapsed) && $stable(out_q) && $stable(pre))
        else $error("clock enable did not freeze");
    // a running, non-differential interval held by the stop contact
    sequence mdt_stopped_s;
        CE_I && !reset_s && stop_s && state == mdt_pkg::MDT_RUN && mode != mdt_pkg::MDT_DIFFERENTIAL;
    endsequence
    // first cycle after release, no tick yet, so the count must not move
    sequence mdt_released_s;
        CE_I && !reset_s && !stop_s && !tick && state == mdt_pkg::MDT_RUN
        && mode != mdt_pkg::MDT_DIFFERENTIAL;
    endsequence
    // release resumes from the frozen count instead of clearing it
    stop_resume_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R5
        mdt_stopped_s ##1 mdt_released_s |=> elapsed == $past(elapsed, 2))
        else $error("stop release lost elapsed time");
    // on-delay expiry sets the output and parks in done
    ondelay_set_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R2
        (CE_I && !reset_s && expire && state == mdt_pkg::MDT_RUN && mode == mdt_pkg::MDT_ON_DELAY)
        |=> out_q && state == mdt_pkg::MDT_DONE)
        else $error("on-delay did not latch");
    // differential pulse ends on expiry while start holds still
    diff_end_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R9
        (CE_I && !reset_s && !start_edge && expire && state == mdt_pkg::MDT_RUN
         && mode == mdt_pkg::MDT_DIFFERENTIAL) |=> !out_q && state == mdt_pkg::MDT_IDLE)
        else $error("differential pulse did not end");
    // a start rise arms timing from zero in the other modes
    arm_run_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R1
        (CE_I && !reset_s && state == mdt_pkg::MDT_IDLE && start_rise && mode != mdt_pkg::MDT_DIFFERENTIAL)
        |=> state == mdt_pkg::MDT_RUN && elapsed == mdt_pkg::TIME_ZERO)
        else $error("start rise did not arm timing");
endmodule
`default_nettype wire

/* File: tb/mdt_contacts.sv */
// partner model: start, reset and stop contacts plus the driven load
// assumes the bench sets the wanted contact levels between clock edges
`timescale 1ns/100ps
`default_nettype none
module mdt_contacts
(
    input wire logic clk_i,
    input wire logic [2:0] want_i,
    input wire logic out_i,
    output logic start_o,
    output logic reset_o,
    output logic stop_o,
    output logic load_on_o
);
    // start closed before power so timing begins at power-up
    initial {stop_o, reset_o, start_o} = 3'h1;
    // contacts move one fixed delay after the edge, like real bounce-free relays
    always @(posedge clk_i)
    begin
        {stop_o, reset_o, start_o} <= #1 want_i;
    end
    // load just follows the timed output
    assign load_on_o = out_i;
endmodule
`default_nettype wire

/* File: tb/test_multimode_delay_timer.sv */
// bench for the multimode delay timer: every mode, stop, reset, power-up start
// assumes 1 tick = 250 cycles with up to one tick of prescaler jitter
`timescale 1ns/100ps
`default_nettype none
module test_multimode_delay_timer;
    logic clk = 1'h0;
    logic rst_n = 1'h0; // power off at start
    logic ce = 1'h1;
    logic [1:0] mode = 2'h0;
    logic [15:0] set_time = 16'h0002;
    logic [2:0] want = 3'h1; // {stop, reset, start}
    logic start, rst_c, stop, out, load_on;
    logic [31:0] seed = 32'h0000003B;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    always #2 clk = ~clk;
    mdt_contacts u_cont (.clk_i(clk), .want_i(want), .out_i(out), .start_o(start),
        .reset_o(rst_c), .stop_o(stop), .load_on_o(load_on));
    mdt_timer dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .MODE_I(mode), .SET_TIME_I(set_time),
        .START_I(start), .RESET_I(rst_c), .STOP_I(stop), .OUT_O(out));
    // repeatable random source
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // interval of t ticks, one tick early allowed for prescaler phase
    function automatic logic in_win(input int c, input int t);
        return c >= (t - 1) * mdt_pkg::TICK_CYC && c <= t * mdt_pkg::TICK_CYC + 8;
    endfunction
    task automatic check(input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // k edges, then settle just past the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // cycles until output reaches v; bounded so a hang ends the run
    task automatic wait_out(input logic v, input int lim);
        n = 0;
        while (out !== v && n < lim)
        begin
            step(1);
            n++;
        end
        if (n >= lim)
        begin
            miscompares++;
            final_report();
        end
    endtask
    initial
    begin
        step(6);
        rst_n = 1'h1;
        // power-up with start already closed
        wait_out(1'h1, 1000);
        check(in_win(n, 2), 1'h1);
        for (int i = 0; i < 8; i++)
        begin
            want = 3'h2; // reset contact, also clears a latched on-delay
            wait_out(1'h0, 10);
            check(load_on, 1'h0);
            // settings move only once reset is seen, so no run meets a new set time
            step(4);
            check(out, 1'h0);
            seed = xorshift(seed);
            mode = 2'(i); // every mode twice
            set_time = 16'(seed[1:0]) + 16'h0003;
            want = 3'h0;
            step(8);
            want = 3'h1; // start closes
            if (mode[1])
            begin
                wait_out(1'h1, 10);
                check(out, 1'h1);
            end
            else
            begin
                step(100);
                check(out, 1'h0);
                if (i == 4)
                begin
                    want = 3'h5; // stop mid-interval
                    step(750);
                    check(out, 1'h0);
                    want = 3'h1;
                end
                wait_out(1'h1, 2000);
                check(in_win(n + 100, set_time), 1'h1);
            end
            if (mode == 2'h3)
            begin
                wait_out(1'h0, 2000);
                want = 3'h0; // start opens while idle
                wait_out(1'h1, 10);
                check(out, 1'h1);
                step(400); // well inside even the shortest pulse
                want = 3'h1; // change part way into the pulse
            end
            if (mode == 2'h0)
            begin
                step(2000);
                check(out, 1'h1);
            end
            else
            begin
                wait_out(1'h0, 2000);
                check(in_win(n, set_time), 1'h1);
                if (mode != 2'h3)
                begin
                    wait_out(1'h1, 2000);
                    check(in_win(n, set_time), 1'h1);
                end
            end
            $display("mode %0d set time %0d done", mode, set_time);
        end
        // power cut during on-start flicker with start held closed
        want = 3'h2;
        step(4);
        mode = 2'h2;
        want = 3'h1;
        wait_out(1'h1, 10);
        step(10);
        rst_n = 1'h0;
        step(1);
        check(out, 1'h0);
        step(2);
        rst_n = 1'h1;
        wait_out(1'h1, 10);
        check(load_on, 1'h1);
        // clock enable low freezes the on phase past its longest length
        ce = 1'h0;
        step(1500);
        check(out, 1'h1);
        ce = 1'h1;
        wait_out(1'h0, 2000);
        check(in_win(n, set_time), 1'h1);
        $display("power cycle and clock enable done");
        final_report();
    end
endmodule
`default_nettype wire
